// ===== hdl/spdpm_in_route.sv
// Input routing: registered copy of one pin toward the peripheral it serves
`default_nettype none
module spdpm_in_route (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  input  wire logic sel,
  input  wire logic idle_val,
  output var  logic route_r
);
  logic route_nxt;

  // ===========================================================
  // Unselected consumers see their idle level, not pin noise
  always_comb begin
    route_nxt = sel ? pin_in : idle_val;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      route_r <= 1'b1;
    end else begin
      route_r <= route_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/spdpm_pad.sv
// Single pad slice: registered output, enable and pull-up for one shared pin
`default_nettype none
module spdpm_pad (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic pu_en,
  output var  logic pad_out_r,
  output var  logic pad_oe_r,
  output var  logic pad_pu_r
);
  // ===========================================================
  // Next-value logic
  logic out_nxt;
  logic oe_nxt;
  logic pu_nxt;

  always_comb begin
    out_nxt = drv_val;
    oe_nxt  = drv_en;
    pu_nxt  = pu_en;
  end

  // ===========================================================
  // Registers: reset leaves the pad as a pulled-up input
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_r <= 1'b0;
      pad_oe_r  <= 1'b0;
      pad_pu_r  <= 1'b1;
    end else begin
      pad_out_r <= out_nxt;
      pad_oe_r  <= oe_nxt;
      pad_pu_r  <= pu_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/spdpm_pin_mux.sv
// Pin multiplexer and pull-up control for decoder-0 and SPI-0 shared pins
`default_nettype none
// Functional notes
// RULE_01: After reset the index pin serves the decoder index input.
// RULE_02: Port C pull-up bit 6 clear disables the index pin pull-up.
// RULE_03: After reset the home pin serves the decoder home input.
// RULE_04: Port C pull-up bit 7 clear disables the home pin pull-up.
// RULE_05: After reset the clock pin serves the SPI clock.
// RULE_06: Port E pull-up bit 4 clear disables the SPI clock pull-up.
// RULE_07: SPI master drives the clock pin; slave takes it as input.
// RULE_08: After reset the master-out pin serves the SPI data function.
// RULE_09: Port E pull-up bit 5 clear disables the master-out pull-up.
// RULE_10: Master presents master-out data half a clock before slave sampling.
// RULE_11: Slave presents master-in data half a clock before master sampling.
// RULE_12: Unselected SPI slave floats its master-in output.
// RULE_13: After reset the master-in pin serves the SPI data function.
// RULE_14: Port E pull-up bit 6 clear disables the master-in pull-up.
// RULE_15: External master asserts low slave select to address a slave.
// RULE_16: Port E pull-up bit 7 clear disables the select pin pull-up.
// RULE_17: In GPIO function each pin direction is set by software.
// RULE_18: After reset the select pin serves the SPI select function.
// RULE_19: In reset master-out driver is off and all pins pulled up.
// RULE_20: Index and home pins may serve timer A channels two and three.
module spdpm_pin_mux (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Function selects and pull-ups from software
  input  wire spdpm_pkg::spdpm_fn_t index_fn_sel,
  input  wire spdpm_pkg::spdpm_fn_t home_fn_sel,
  input  wire logic [3:0]           spi_gpio_sel,
  input  wire logic [7:0]           port_c_pullup_enable,
  input  wire logic [7:0]           port_e_pullup_enable,
  // GPIO direction and output values, port C bits 7:6, port E bits 7:4
  input  wire logic [7:0]           port_c_dir,
  input  wire logic [7:0]           port_c_dout,
  input  wire logic [7:0]           port_e_dir,
  input  wire logic [7:0]           port_e_dout,
  // Timer A channel two/three pin side
  input  wire logic                 timer_a_channel_two_out,
  input  wire logic                 timer_a_channel_two_oe,
  input  wire logic                 timer_a_channel_three_out,
  input  wire logic                 timer_a_channel_three_oe,
  // SPI core side
  input  wire logic                 spi_master,
  input  wire logic                 spi_clk_out,
  input  wire logic                 spi_mosi_out,
  input  wire logic                 spi_miso_out,
  // Pin inputs
  input  wire logic                 decoder_zero_index_in,
  input  wire logic                 decoder_zero_home_in,
  input  wire logic                 spi_primary_clock_pin_in,
  input  wire logic                 spi_primary_out_pin_in,
  input  wire logic                 spi_primary_in_pin_in,
  input  wire logic                 spi_primary_select_pin_in,
  // Pin outputs: value, enable, pull-up (bit0 index, 1 home, 2 clk, 3 mosi, 4 miso, 5 ss)
  output var  logic [5:0]           pin_out,
  output var  logic [5:0]           pin_oe,
  output var  logic [5:0]           pin_pu,
  // Routed inputs toward peripherals and GPIO readback
  output var  logic                 dec_index_r,
  output var  logic                 dec_home_r,
  output var  logic                 timer_a_channel_two_in_r,
  output var  logic                 timer_a_channel_three_in_r,
  output var  logic                 spi_clk_in_r,
  output var  logic                 spi_mosi_in_r,
  output var  logic                 spi_miso_in_r,
  output var  logic                 spi_select_n_r,
  output var  logic [7:0]           port_c_din_r,
  output var  logic [7:0]           port_e_din_r
);
  import spdpm_pkg::*;

  // ===========================================================
  // Per-pin drive decision
  logic [5:0] drv_en;
  logic [5:0] drv_val;
  logic [5:0] pu_en;
  logic       spi_sel_act;

  // Function selects come up primary through the caller's reset;
  // this block adds nothing that could override them.
  always_comb begin
    drv_en  = '0;
    drv_val = '0;
    // Index pin: decoder input, timer channel two, or GPIO [RULE_01] [RULE_20]
    unique case (index_fn_sel)
      SPDPM_FN_TIMER: begin
        drv_en[0]  = timer_a_channel_two_oe;
        drv_val[0] = timer_a_channel_two_out;
      end
      SPDPM_FN_GPIO: begin
        drv_en[0]  = port_c_dir[PC_BIT_INDEX]; // [RULE_17]
        drv_val[0] = port_c_dout[PC_BIT_INDEX];
      end
      default: begin
        drv_en[0]  = 1'b0;
        drv_val[0] = 1'b0;
      end
    endcase
    // Home pin: decoder input, timer channel three, or GPIO [RULE_03] [RULE_20]
    unique case (home_fn_sel)
      SPDPM_FN_TIMER: begin
        drv_en[1]  = timer_a_channel_three_oe;
        drv_val[1] = timer_a_channel_three_out;
      end
      SPDPM_FN_GPIO: begin
        drv_en[1]  = port_c_dir[PC_BIT_HOME]; // [RULE_17]
        drv_val[1] = port_c_dout[PC_BIT_HOME];
      end
      default: begin
        drv_en[1]  = 1'b0;
        drv_val[1] = 1'b0;
      end
    endcase
    // Clock pin: master drives, slave listens [RULE_05] [RULE_07]
    if (spi_gpio_sel[0]) begin
      drv_en[2]  = port_e_dir[PE_BIT_SCLK]; // [RULE_17]
      drv_val[2] = port_e_dout[PE_BIT_SCLK];
    end else begin
      drv_en[2]  = spi_master; // [RULE_07]
      drv_val[2] = spi_clk_out;
    end
    // Master-out pin: in SPI use driven only by a master; core times data [RULE_08] [RULE_10]
    if (spi_gpio_sel[1]) begin
      drv_en[3]  = port_e_dir[PE_BIT_MOSI]; // [RULE_17]
      drv_val[3] = port_e_dout[PE_BIT_MOSI];
    end else begin
      drv_en[3]  = spi_master; // [RULE_10]
      drv_val[3] = spi_mosi_out;
    end
    // Master-in pin: in SPI use selected slave drives, else floats [RULE_13] [RULE_11] [RULE_12]
    if (spi_gpio_sel[2]) begin
      drv_en[4]  = port_e_dir[PE_BIT_MISO]; // [RULE_17]
      drv_val[4] = port_e_dout[PE_BIT_MISO];
    end else begin
      drv_en[4]  = !spi_master && spi_sel_act; // [RULE_12]
      drv_val[4] = spi_miso_out; // [RULE_11]
    end
    // Select pin: input only in SPI use [RULE_18]
    if (spi_gpio_sel[3]) begin
      drv_en[5]  = port_e_dir[PE_BIT_SS]; // [RULE_17]
      drv_val[5] = port_e_dout[PE_BIT_SS];
    end else begin
      drv_en[5]  = 1'b0;
      drv_val[5] = 1'b0;
    end
  end

  // ===========================================================
  // Pull-up enables straight from the port pull-up registers
  always_comb begin
    pu_en[0] = port_c_pullup_enable[PC_BIT_INDEX]; // [RULE_02]
    pu_en[1] = port_c_pullup_enable[PC_BIT_HOME];  // [RULE_04]
    pu_en[2] = port_e_pullup_enable[PE_BIT_SCLK];  // [RULE_06]
    pu_en[3] = port_e_pullup_enable[PE_BIT_MOSI];  // [RULE_09]
    pu_en[4] = port_e_pullup_enable[PE_BIT_MISO];  // [RULE_14]
    pu_en[5] = port_e_pullup_enable[PE_BIT_SS];    // [RULE_16]
  end

  // Live select, active low, uses the raw pin so the enable is not late
  assign spi_sel_act = !spi_primary_select_pin_in && !spi_gpio_sel[3]; // [RULE_15]

  // ===========================================================
  // Pad slices; reset forces output off and pull-up on [RULE_19]
  genvar gi;

  // Index pin pad
  spdpm_pad u_pad_index (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[0]),
    .drv_val   (drv_val[0]),
    .pu_en     (pu_en[0]),
    .pad_out_r (pin_out[0]),
    .pad_oe_r  (pin_oe[0]),
    .pad_pu_r  (pin_pu[0])
  );

  // Home pin pad
  spdpm_pad u_pad_home (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[1]),
    .drv_val   (drv_val[1]),
    .pu_en     (pu_en[1]),
    .pad_out_r (pin_out[1]),
    .pad_oe_r  (pin_oe[1]),
    .pad_pu_r  (pin_pu[1])
  );

  // Serial clock pin pad
  spdpm_pad u_pad_clock (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[2]),
    .drv_val   (drv_val[2]),
    .pu_en     (pu_en[2]),
    .pad_out_r (pin_out[2]),
    .pad_oe_r  (pin_oe[2]),
    .pad_pu_r  (pin_pu[2])
  );

  // Master-out pin pad; stays a pulled-up input while in reset [RULE_19]
  spdpm_pad u_pad_mosi (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[3]),
    .drv_val   (drv_val[3]),
    .pu_en     (pu_en[3]),
    .pad_out_r (pin_out[3]),
    .pad_oe_r  (pin_oe[3]),
    .pad_pu_r  (pin_pu[3])
  );

  // Master-in pin pad
  spdpm_pad u_pad_miso (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[4]),
    .drv_val   (drv_val[4]),
    .pu_en     (pu_en[4]),
    .pad_out_r (pin_out[4]),
    .pad_oe_r  (pin_oe[4]),
    .pad_pu_r  (pin_pu[4])
  );

  // Slave select pin pad
  spdpm_pad u_pad_select (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .drv_en    (drv_en[5]),
    .drv_val   (drv_val[5]),
    .pu_en     (pu_en[5]),
    .pad_out_r (pin_out[5]),
    .pad_oe_r  (pin_oe[5]),
    .pad_pu_r  (pin_pu[5])
  );

  // ===========================================================
  // Input routing; unselected consumers see the idle-high level
  logic [7:0] rin;
  logic [7:0] rsel;
  logic [7:0] rout;

  always_comb begin
    rin  = {spi_primary_select_pin_in, spi_primary_in_pin_in, spi_primary_out_pin_in,
            spi_primary_clock_pin_in, decoder_zero_home_in, decoder_zero_index_in,
            decoder_zero_home_in, decoder_zero_index_in};
    rsel = {!spi_gpio_sel[3], !spi_gpio_sel[2] && spi_master,
            !spi_gpio_sel[1] && !spi_master, !spi_gpio_sel[0] && !spi_master,
            home_fn_sel == SPDPM_FN_TIMER, index_fn_sel == SPDPM_FN_TIMER,
            home_fn_sel == SPDPM_FN_PRIMARY, index_fn_sel == SPDPM_FN_PRIMARY};
  end

  generate
    for (gi = 0; gi < 8; gi++) begin : g_route
      spdpm_in_route u_route (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .pin_in   (rin[gi]),
        .sel      (rsel[gi]),
        .idle_val (1'b1),
        .route_r  (rout[gi])
      );
    end
  endgenerate

  always_comb begin
    dec_index_r                = rout[0];
    dec_home_r                 = rout[1];
    timer_a_channel_two_in_r   = rout[2];
    timer_a_channel_three_in_r = rout[3];
    spi_clk_in_r               = rout[4];
    spi_mosi_in_r              = rout[5];
    spi_miso_in_r              = rout[6];
    spi_select_n_r             = rout[7];
  end

  // ===========================================================
  // GPIO readback of the pin levels in all functions
  logic [7:0] pc_din_nxt;
  logic [7:0] pe_din_nxt;

  always_comb begin
    pc_din_nxt               = 8'h00;
    pe_din_nxt               = 8'h00;
    // Port C lines six and seven carry index and home
    pc_din_nxt[PC_BIT_INDEX] = decoder_zero_index_in;
    pc_din_nxt[PC_BIT_HOME]  = decoder_zero_home_in;
    // Port E lines four to seven carry the SPI pins
    pe_din_nxt[PE_BIT_SCLK]  = spi_primary_clock_pin_in;
    pe_din_nxt[PE_BIT_MOSI]  = spi_primary_out_pin_in;
    pe_din_nxt[PE_BIT_MISO]  = spi_primary_in_pin_in;
    pe_din_nxt[PE_BIT_SS]    = spi_primary_select_pin_in;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_c_din_r <= 8'h00;
      port_e_din_r <= 8'h00;
    end else begin
      port_c_din_r <= pc_din_nxt;
      port_e_din_r <= pe_din_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/spdpm_pkg.sv
// Package: constants and types for the decoder/SPI pin multiplexer
`default_nettype none
package spdpm_pkg;
  // Pin function selection codes
  typedef enum logic [1:0] {
    SPDPM_FN_PRIMARY = 2'h0,
    SPDPM_FN_TIMER   = 2'h1,
    SPDPM_FN_GPIO    = 2'h2,
    SPDPM_FN_RSVD    = 2'h3
  } spdpm_fn_t;

  // Pull-up register bit positions
  localparam int unsigned PC_BIT_INDEX = 6;
  localparam int unsigned PC_BIT_HOME  = 7;
  localparam int unsigned PE_BIT_SCLK  = 4;
  localparam int unsigned PE_BIT_MOSI  = 5;
  localparam int unsigned PE_BIT_MISO  = 6;
  localparam int unsigned PE_BIT_SS    = 7;

  // Reset values
  localparam logic [7:0] PULLUP_RST   = 8'hff;
  localparam logic [1:0] FN_RST       = 2'h0;
  localparam logic       GPIO_DIR_RST = 1'b0;
  localparam logic       GPIO_OUT_RST = 1'b0;
endpackage
`default_nettype wire

// ===== verification/spdpm_peer_model.sv
// Far-side model: SPI peer and encoder sensor on the six shared pins
`default_nettype none
module spdpm_peer_model (
  input  wire logic       mclk,
  input  wire logic       pm,
  input  wire logic       frm,
  input  wire logic [1:0] enc,
  input  wire logic [5:0] po,
  input  wire logic [5:0] oe,
  input  wire logic [5:0] pu,
  output var  logic [5:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] drv, val;
  logic [5:0] last = 6'h00;
  logic       sck = 1'b0;
  logic       dat = 1'b0;
  // Clock stands still outside a frame; data moves as the clock falls
  always @(posedge mclk) begin
    sck <= frm & ~sck;
    if (sck) dat <= ~dat;
    last <= lvl;
  end
  // Master peer drives clock, data and a low select while framing
  assign drv = {pm, ~pm & frm, pm, pm, 2'h3};
  assign val = {~frm, dat, dat, sck, enc};
  // Released lines rise on the pull-up, else show the inverse of the last level
  always_comb for (int i = 0; i < 6; i++)
    lvl[i] = oe[i] ? po[i] : drv[i] ? val[i] : pu[i] | ~last[i];
endmodule
`default_nettype wire

// ===== verification/spdpm_pin_mux_monitor.sv
// Checker: pin relations of the decoder/SPI pin multiplexer
`default_nettype none
module spdpm_pin_mux_monitor (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [3:0] spi_gpio_sel,
  input wire logic [7:0] port_c_pullup_enable,
  input wire logic [7:0] port_e_pullup_enable,
  input wire logic [7:0] port_e_dir,
  input wire logic       spi_master,
  input wire logic       spi_clk_out,
  input wire logic       spi_mosi_out,
  input wire logic       spi_miso_out,
  input wire logic       spi_primary_select_pin_in,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pin_pu
);
  logic       rdy_r, m_r, ss_r, co_r, mo_r, so_r, d7_r;
  logic [3:0] g_r;
  logic [5:0] pu_r;
  // Pins are judged against the previous edge, so wait one edge after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdy_r <= 1'b0;
    else rdy_r <= 1'b1;
  end
  // Inputs of the previous edge
  always_ff @(posedge mclk) begin
    {m_r, ss_r, co_r, mo_r, so_r} <= {spi_master, spi_primary_select_pin_in, spi_clk_out,
      spi_mosi_out, spi_miso_out};
    {d7_r, g_r} <= {port_e_dir[7], spi_gpio_sel};
    pu_r <= {port_e_pullup_enable[7:4], port_c_pullup_enable[7:6]};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence held_reset;
    !rst_n ##1 !rst_n;
  endsequence
  pu_port_c_a: assert property (rdy_r |-> pin_pu[1:0] == pu_r[1:0])
    else $error("port C pull-up wrong");
  pu_port_e_a: assert property (
    rdy_r |-> pin_pu[5:2] == pu_r[5:2]) else $error("port E pull-up wrong");
  reset_pins_a: assert property (disable iff (1'b0)
    held_reset |-> pin_oe == 6'h00 && pin_pu == 6'h3f) else $error("reset pin state wrong");
  clk_drive_a: assert property (
    rdy_r && !g_r[0] && m_r |-> pin_oe[2] && pin_out[2] == co_r) else $error("clock drive");
  clk_listen_a: assert property (rdy_r && !g_r[0] && !m_r |-> !pin_oe[2])
    else $error("clock not released");
  mosi_drive_a: assert property (
    rdy_r && !g_r[1] && m_r |-> pin_oe[3] && pin_out[3] == mo_r) else $error("mosi drive");
  miso_float_a: assert property (
    rdy_r && !g_r[2] && (m_r || ss_r || g_r[3]) |-> !pin_oe[4]) else $error("miso not floated");
  miso_drive_a: assert property (
    rdy_r && !g_r[2] && !g_r[3] && !m_r && !ss_r |-> pin_oe[4] && pin_out[4] == so_r)
    else $error("miso drive");
  ss_dir_a: assert property (rdy_r && g_r[3] |-> pin_oe[5] == d7_r)
    else $error("select pin direction");
endmodule
bind spdpm_pin_mux spdpm_pin_mux_monitor u_mon (.mclk, .rst_n, .spi_gpio_sel,
  .port_c_pullup_enable, .port_e_pullup_enable, .port_e_dir, .spi_master, .spi_clk_out,
  .spi_mosi_out, .spi_miso_out, .spi_primary_select_pin_in, .pin_out, .pin_oe, .pin_pu);
`default_nettype wire

// ===== verification/spdpm_pin_mux_tb_top.sv
// Self-checking bench for the decoder/SPI pin multiplexer
`default_nettype none
module spdpm_pin_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spdpm_pkg::*;
  logic        mclk, rst_n, rq, ph, sm, co, mo, so, pm, frm, t2o, t2e, t3o, t3e;
  logic [1:0]  enc;
  logic [3:0]  gs;
  logic [7:0]  cpu, epu, cdir, cdo, edir, edo;
  spdpm_fn_t   ifn, hfn;
  wire  [5:0]  po, poe, ppu, lvl;
  wire  [7:0]  rt, cdi, edi;
  logic [63:0] q[$];
  logic [63:0] nt;
  int          n_mismatch, compares, cyc;
  spdpm_pin_mux DUT (.mclk(mclk), .rst_n(rst_n), .index_fn_sel(ifn), .home_fn_sel(hfn),
    .spi_gpio_sel(gs), .port_c_pullup_enable(cpu), .port_e_pullup_enable(epu),
    .port_c_dir(cdir), .port_c_dout(cdo), .port_e_dir(edir), .port_e_dout(edo),
    .timer_a_channel_two_out(t2o), .timer_a_channel_two_oe(t2e),
    .timer_a_channel_three_out(t3o), .timer_a_channel_three_oe(t3e), .spi_master(sm),
    .spi_clk_out(co), .spi_mosi_out(mo), .spi_miso_out(so), .decoder_zero_index_in(lvl[0]),
    .decoder_zero_home_in(lvl[1]), .spi_primary_clock_pin_in(lvl[2]),
    .spi_primary_out_pin_in(lvl[3]), .spi_primary_in_pin_in(lvl[4]),
    .spi_primary_select_pin_in(lvl[5]), .pin_out(po), .pin_oe(poe), .pin_pu(ppu),
    .dec_index_r(rt[7]), .dec_home_r(rt[6]), .timer_a_channel_two_in_r(rt[5]),
    .timer_a_channel_three_in_r(rt[4]), .spi_clk_in_r(rt[3]), .spi_mosi_in_r(rt[2]),
    .spi_miso_in_r(rt[1]), .spi_select_n_r(rt[0]), .port_c_din_r(cdi), .port_e_din_r(edi));
  spdpm_peer_model peer (.mclk(mclk), .pm(pm), .frm(frm), .enc(enc), .po(po), .oe(poe),
    .pu(ppu), .lvl(lvl));
  // Expected pins and routed inputs, then a mask of the bits that are defined
  function automatic logic [63:0] expect_now();
    logic [5:0] o, e, v;
    logic [7:0] r;
    v = {<<{lvl}};
    o = {edo[7:4], cdo[7:6]};
    e = {edir[7:4], cdir[7:6]};
    if (ifn != SPDPM_FN_GPIO) {o[0], e[0]} = {t2o, ifn == SPDPM_FN_TIMER && t2e};
    if (hfn != SPDPM_FN_GPIO) {o[1], e[1]} = {t3o, hfn == SPDPM_FN_TIMER && t3e};
    if (!gs[0]) {o[2], e[2]} = {co, sm};
    if (!gs[1]) {o[3], e[3]} = {mo, sm};
    if (!gs[2]) {o[4], e[4]} = {so, !sm && !lvl[5] && !gs[3]};
    if (!gs[3]) e[5] = 1'b0;
    // Consumers that do not own their pin read high; order index, home, t2, t3, clk..ss
    r = {ifn != SPDPM_FN_PRIMARY, hfn != SPDPM_FN_PRIMARY, ifn != SPDPM_FN_TIMER,
      hfn != SPDPM_FN_TIMER, gs[0] | sm, gs[1] | sm, gs[2] | !sm, gs[3]};
    return {o, e, epu[7:4], cpu[7:6], r | {v[5:4], v}, lvl[1:0], lvl[5:2], e, 12'hfff,
      14'h3fff};
  endfunction
  task automatic cmp_pin(input logic [17:0] g, e, m);
    compares++;
    n_mismatch += ((g & m) !== (e & m));
    if ((g & m) !== (e & m)) $display("[ERR] %0t pins got %h exp %h", $time, g & m, e & m);
  endtask
  task automatic cmp_in(input logic [13:0] g, e, m);
    compares++;
    n_mismatch += ((g & m) !== (e & m));
    if ((g & m) !== (e & m)) $display("[ERR] %0t inputs got %h exp %h", $time, g & m, e & m);
  endtask
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Driver: note what this edge must produce, then move the inputs
  always @(posedge mclk) begin
    rst_n <= rq;
    cyc <= cyc + 1;
    if (!rq || !rst_n) q.push_back({32'h000f_ffc0, 32'hffff_ffff});
    else q.push_back(expect_now());
    if (ph) begin
      ifn <= spdpm_fn_t'($urandom_range(3, 0));
      hfn <= spdpm_fn_t'($urandom_range(3, 0));
      {t2o, t2e, t3o, t3e, co, mo, so, sm} <= 8'($urandom);
      {gs, enc} <= 6'($urandom);
      {cpu, epu, cdir, cdo} <= $urandom;
      {edir, edo} <= 16'($urandom);
      if (cyc[4:0] == 5'h00) {pm, frm} <= 2'($urandom);
    end
    if (cyc == 8000) begin
      n_mismatch++;
      results();
    end
  end
  // Watcher: each settled result is taken against the oldest note
  always @(negedge mclk) begin
    if (q.size() != 0) begin
      nt = q.pop_front();
      cmp_pin({po, poe, ppu}, nt[63:46], nt[31:14]);
      cmp_in({rt, cdi[7:6], edi[7:4]}, nt[45:32], nt[13:0]);
    end
  end
  // Defaults after reset, slave then master, then random traffic around a second reset
  initial begin
    void'($urandom(93));
    {rst_n, rq, ph, sm, co, mo, so, frm, t2o, t2e, t3o, t3e, gs, cdir, cdo, edir, edo} = '0;
    {cpu, epu, pm, enc} = {PULLUP_RST, PULLUP_RST, 3'h5};
    ifn = spdpm_fn_t'(FN_RST);
    hfn = spdpm_fn_t'(FN_RST);
    {n_mismatch, compares, cyc} = '0;
    repeat (2) @(posedge mclk);
    rq <= 1'b1;
    repeat (4) @(posedge mclk);
    frm <= 1'b1;
    repeat (16) @(posedge mclk);
    {pm, sm} <= 2'h1;
    repeat (16) @(posedge mclk);
    ph <= 1'b1;
    repeat (3000) @(posedge mclk);
    rq <= 1'b0;
    repeat (3) @(posedge mclk);
    rq <= 1'b1;
    repeat (3000) @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
